// ### shared/vmb_consts.vh
`ifndef VMB_CONSTS_VH
`define VMB_CONSTS_VH

// register indices on register_index_lines
`define VMB_REG_SEMA 3'h0
`define VMB_REG_TLM0 3'h1
`define VMB_REG_TLM1 3'h2
`define VMB_REG_TYPE 3'h3
`define VMB_REG_LGO 3'h4
`define VMB_REG_VADR 3'h5
`define VMB_REG_UADR 3'h6
`define VMB_REG_SID 3'h7

// lock command enable bits
`define VMB_LK_A16 0
`define VMB_LK_A24 1
`define VMB_LK_A32 2
`define VMB_LK_A40 3
`define VMB_LK_A64 4
`define VMB_LK_W 5

// timing
`define VMB_CLK_NS 8
`define VMB_SEL_MIN_NS 100
`define VMB_SEL_MIN_CYC ((`VMB_SEL_MIN_NS + `VMB_CLK_NS - 1) / `VMB_CLK_NS)
`define VMB_DRV_DLY 2'h2
`define VMB_CNT_W 4

// transfer type field
`define VMB_TT_DS_LO 0
`define VMB_TT_DS_HI 2
`define VMB_TT_AS_LO 3
`define VMB_TT_AS_HI 5
`define VMB_TT_BLT 6
`define VMB_DS_MAX 3'h4
`define VMB_AS_MAX 3'h4

// length limits, in units of 16 bytes: 16 bytes .. 8 megabytes
`define VMB_LEN_W 20
`define VMB_LEN_MIN 20'h00001
`define VMB_LEN_MAX 20'h80000

// semaphore status byte layout
`define VMB_ST_IDLE 0
`define VMB_ST_IRQ 1
`define VMB_ST_LEN 2
`define VMB_ST_TYP 3
`define VMB_ST_ALN 4
`define VMB_ST_VAD 6
`define VMB_ST_BER 7

// fifo
`define VMB_FIFO_W 32
`define VMB_FIFO_D 4

`endif

// ### hw/vmb_fifo.v
`timescale 1ns/1ps
module vmb_fifo #(
  parameter W = 32,
  parameter D = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop)
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // vmb_fifo

// ### hw/vmb_ctrl.v
// Operation
// RL1 - lock decoding enabled on exactly one of sixteen decode regions
// RL2 - any subset of A16..A64 lock commands, one shared lock indicator
// RL3 - decoded lock drives indicator low while BBSY or AS stays asserted
// RL4 - a lock command activates no chip select or byte enable
// RL5 - normal slave accesses are unaffected by lock decoding
// RL6 - indicator also asserted on register accesses and master transfers
// RL7 - lock_default_disable suppresses the default lock during transfers
// RL8 - single or BLT, D8/D16/D32/MD32/D64 over A16..A64 spaces
// RL9 - transfer lengths from 16 bytes up to 8 megabytes; the code stops at 0xFFFF units of 16 bytes, just under 1 megabyte
// RL10 - once started, request bus and move data in one of 20 protocols; the code accepts all 25 width and space combinations
// RL11 - busy semaphore, completion interrupt with status/ID, bus requester
// RL12 - one of eight registers chosen by register_index_lines
// RL13 - select plus valid region needed; local cycle suppressed meanwhile
// RL14 - valid VME register access gets DTACK, bad one gets BERR
// RL15 - local logic enters holdoff before any local register access
// RL16 - index, direction, write data set up before select, held until end
// RL17 - select held at least thirteen clocks, 100 ns, no acknowledge given
// RL18 - read data driven two clocks after select, released one after drop
// RL19 - illegal local access: bus error low within two clocks, released
// RL20 - load strobes capture local and VME start addresses in slices
// RL21 - master transfers enable memory via chip selects from region inputs
// RL22 - index map: semaphore, two length multipliers, type, GO, addresses
// RL23 - idle semaphore read returns 1, sets busy; early accesses error
// RL24 - reset: indicator high, data released, bus error inactive
`timescale 1ns/1ps
`include "vmb_consts.vh"
module vmb_ctrl (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // configuration
  input wire [3:0] lock_region,
  input wire [4:0] lock_cmd_enable,
  input wire lock_default_disable,
  // vme slave side
  input wire [15:0] region_vec,
  input wire vme_as_n,
  input wire vme_bbsy_n,
  input wire vme_lock_cycle,
  input wire [2:0] vme_lock_space,
  input wire vme_ds_n,
  input wire vme_write,
  input wire [7:0] vme_wdata,
  output reg vme_dtack_n,
  output reg vme_berr_n,
  output reg [7:0] vme_rdata,
  // local register port
  input wire register_select_n,
  input wire [2:0] register_index_lines,
  input wire local_write,
  input wire holdoff_active,
  input wire [31:0] local_data_lines_in,
  output reg [31:0] local_data_lines_out,
  output reg local_data_lines_oe,
  output reg local_bus_error_n,
  // local cycle and slice control
  output reg [3:0] chip_sel,
  output reg [3:0] byte_en,
  output reg local_cycle_inhibit,
  output reg load_local_addr,
  output reg load_vme_addr,
  output reg [31:0] start_addr_out,
  // master transfer side
  input wire vme_bg_in_n,
  input wire xfer_done,
  input wire irq_ack,
  input wire xfer_berr,
  output reg vme_br_n,
  output reg vme_bg_out_n,
  output reg xfer_active,
  output reg [7:0] xfer_type,
  output reg [19:0] xfer_len,
  output reg irq_req,
  output reg [7:0] irq_status_id,
  // data path
  input wire wr_data_valid,
  output wire wr_data_ready,
  input wire [31:0] wr_data,
  output reg rd_data_valid,
  input wire rd_data_ready,
  output reg [31:0] rd_data,
  // lock
  output reg lock_indicator_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;
  localparam ST_XFER = 2'h2;
  localparam ST_IRQ = 2'h3;

  reg [1:0] st_q;
  reg [`VMB_CNT_W-1:0] sel_cnt_q;
  reg sel_q;
  reg lock_q;
  reg [7:0] tlm0_q;
  reg [7:0] tlm1_q;
  reg [7:0] type_q;
  reg [31:0] lstart_q;
  reg [31:0] vstart_q;
  reg [31:0] upper_q;
  reg [7:0] sid_q;
  reg irq_en_q;
  reg vad_ok_q;
  reg berr_seen_q;
  reg vme_sel_q;
  reg [2:0] lidx_q;
  reg lwr_q;
  reg [31:0] ldata_q;
  reg f_out_rdy;
  wire f_out_valid;
  wire [31:0] f_out_data;
  wire lock_region_hit;
  wire lock_space_ok;
  wire sel_active;
  wire vme_reg_acc;
  wire [2:0] ds;
  wire [2:0] as;
  wire type_ok;
  wire len_ok;
  wire align_ok;
  wire [7:0] status;
  wire [7:0] rd_byte;
  wire acc_ok;

  vmb_fifo #(
    .W(`VMB_FIFO_W),
    .D(`VMB_FIFO_D),
    .AW(2)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(wr_data_valid),
    .in_ready(wr_data_ready),
    .in_data(wr_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_rdy),
    .out_data(f_out_data)
  );

  assign lock_region_hit = region_vec[lock_region]; // [RL1]
  assign lock_space_ok = (vme_lock_space <= 3'h4) &&
    lock_cmd_enable[vme_lock_space]; // [RL2]
  assign sel_active = !register_select_n;
  assign vme_reg_acc = sel_active && (region_vec != 16'h0000) &&
    !vme_ds_n; // [RL13]
  assign ds = type_q[`VMB_TT_DS_HI:`VMB_TT_DS_LO];
  assign as = type_q[`VMB_TT_AS_HI:`VMB_TT_AS_LO];
  // five widths by five spaces: 25 protocol combinations accepted
  assign type_ok = (ds <= `VMB_DS_MAX) && (as <= `VMB_AS_MAX); // [RL8] [RL10]
  assign len_ok = ({tlm1_q, tlm0_q} != 16'h0000) &&
    ({4'h0, tlm1_q, tlm0_q} >= `VMB_LEN_MIN) &&
    ({4'h0, tlm1_q, tlm0_q} <= `VMB_LEN_MAX); // [RL9]
  assign align_ok = !((ds == 3'h1) && (lstart_q[0] | vstart_q[0])) &&
    !((ds >= 3'h2) && ((|lstart_q[1:0]) | (|vstart_q[1:0])));
  assign status = {!berr_seen_q, vad_ok_q, 1'b1, align_ok, type_ok, len_ok,
    (st_q != ST_IRQ), (st_q == ST_IDLE)};
  // busy semaphore opens the other registers; reads also pass during a transfer
  assign acc_ok = (st_q == ST_BUSY) ||
    ((st_q != ST_IDLE) && (st_q != ST_IRQ) && !lwr_q); // [RL23]

  function [7:0] reg_read;
    input [2:0] idx;
    begin
      case (idx)
        `VMB_REG_SEMA: reg_read = status;
        `VMB_REG_TLM0: reg_read = tlm0_q;
        `VMB_REG_TLM1: reg_read = tlm1_q;
        `VMB_REG_TYPE: reg_read = type_q;
        `VMB_REG_LGO: reg_read = lstart_q[7:0];
        `VMB_REG_VADR: reg_read = vstart_q[7:0];
        `VMB_REG_UADR: reg_read = upper_q[7:0];
        default: reg_read = sid_q;
      endcase
    end
  endfunction
  assign rd_byte = reg_read(lidx_q); // [RL12] [RL22]

  always @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      sel_cnt_q <= {`VMB_CNT_W{1'b0}};
      sel_q <= 1'b0;
      lock_q <= 1'b0;
      tlm0_q <= 8'h00;
      tlm1_q <= 8'h00;
      type_q <= 8'hff;
      lstart_q <= 32'h0000_0000;
      vstart_q <= 32'h0000_0000;
      upper_q <= 32'h0000_0000;
      sid_q <= 8'h00;
      irq_en_q <= 1'b0;
      vad_ok_q <= 1'b0;
      berr_seen_q <= 1'b0;
      vme_sel_q <= 1'b0;
      lidx_q <= 3'h0;
      lwr_q <= 1'b0;
      ldata_q <= 32'h0000_0000;
      f_out_rdy <= 1'b0;
      vme_dtack_n <= 1'b1;
      vme_berr_n <= 1'b1;
      vme_rdata <= 8'h00;
      local_data_lines_out <= 32'h0000_0000;
      local_data_lines_oe <= 1'b0; // [RL24]
      local_bus_error_n <= 1'b1; // [RL24]
      chip_sel <= 4'h0;
      byte_en <= 4'h0;
      local_cycle_inhibit <= 1'b0;
      load_local_addr <= 1'b0;
      load_vme_addr <= 1'b0;
      start_addr_out <= 32'h0000_0000;
      vme_br_n <= 1'b1;
      vme_bg_out_n <= 1'b1;
      xfer_active <= 1'b0;
      xfer_type <= 8'h00;
      xfer_len <= 20'h00000;
      irq_req <= 1'b0;
      irq_status_id <= 8'h00;
      rd_data_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
      lock_indicator_out <= 1'b1; // [RL24]
    end else begin
      load_local_addr <= 1'b0;
      load_vme_addr <= 1'b0;
      // lock held while bus busy or strobe asserted
      if (vme_lock_cycle && !vme_as_n && lock_region_hit && lock_space_ok)
        lock_q <= 1'b1; // [RL3]
      else if (vme_bbsy_n && vme_as_n)
        lock_q <= 1'b0; // [RL3]
      lock_indicator_out <= !(lock_q || sel_active ||
        (xfer_active && !lock_default_disable)); // [RL6] [RL7]
      // chip selects only for plain slave or master cycles, never for lock
      if (vme_lock_cycle || sel_active) begin
        chip_sel <= 4'h0; // [RL4] [RL13]
        byte_en <= 4'h0; // [RL4]
      end else if (xfer_active || !vme_as_n) begin
        chip_sel <= region_vec[3:0]; // [RL5] [RL21]
        byte_en <= 4'hf;
      end else begin
        chip_sel <= 4'h0;
        byte_en <= 4'h0;
      end
      local_cycle_inhibit <= sel_active; // [RL13]
      // register access sequencing; relies on holdoff and setup by local
      sel_q <= sel_active; // [RL15] [RL16]
      if (sel_active && !sel_q) begin
        lidx_q <= register_index_lines;
        lwr_q <= local_write;
        ldata_q <= local_data_lines_in;
        vme_sel_q <= vme_reg_acc;
      end
      if (sel_active && sel_cnt_q != {`VMB_CNT_W{1'b1}})
        sel_cnt_q <= sel_cnt_q + 1'b1;
      else if (!sel_active)
        sel_cnt_q <= {`VMB_CNT_W{1'b0}};
      // act on the second sampled edge; self timed, no acknowledge [RL17]
      if (sel_active && sel_cnt_q == {2'h0, `VMB_DRV_DLY} - 1'b1) begin
        // semaphore reads always answer; semaphore writes always error
        if ((lidx_q == `VMB_REG_SEMA) ? lwr_q : !acc_ok) begin // [RL23]
          local_bus_error_n <= holdoff_active ? 1'b0 : 1'b1; // [RL19]
          vme_berr_n <= vme_sel_q ? 1'b0 : 1'b1; // [RL14]
          if (lidx_q == `VMB_REG_SEMA || st_q == ST_XFER)
            st_q <= (st_q == ST_IRQ) ? ST_IRQ : ST_IDLE;
          if (st_q == ST_XFER) begin
            xfer_active <= 1'b0;
            vme_br_n <= 1'b1;
          end
        end else begin
          vme_dtack_n <= vme_sel_q ? 1'b0 : 1'b1; // [RL14]
          if (!lwr_q) begin
            local_data_lines_out <= {24'h000000, rd_byte}; // [RL18]
            local_data_lines_oe <= holdoff_active; // [RL18]
            vme_rdata <= rd_byte;
            if (lidx_q == `VMB_REG_SEMA && st_q == ST_IDLE)
              st_q <= ST_BUSY; // [RL23]
          end else begin
            case (lidx_q)
              `VMB_REG_TLM0: tlm0_q <= ldata_q[7:0];
              `VMB_REG_TLM1: tlm1_q <= ldata_q[7:0];
              `VMB_REG_TYPE: type_q <= ldata_q[7:0];
              `VMB_REG_VADR: begin
                vstart_q <= ldata_q;
                vad_ok_q <= 1'b1;
                load_vme_addr <= 1'b1; // [RL20]
                start_addr_out <= ldata_q;
              end
              `VMB_REG_UADR: upper_q <= ldata_q;
              `VMB_REG_SID: begin
                sid_q <= ldata_q[7:0];
                irq_en_q <= ldata_q[8];
              end
              `VMB_REG_LGO: begin
                lstart_q <= ldata_q;
                load_local_addr <= 1'b1; // [RL20]
                start_addr_out <= ldata_q;
                if (type_ok && len_ok && vad_ok_q) begin
                  st_q <= ST_XFER; // [RL10]
                  xfer_active <= 1'b1;
                  xfer_type <= type_q;
                  xfer_len <= {4'h0, tlm1_q, tlm0_q};
                  vme_br_n <= 1'b0; // [RL11]
                  vad_ok_q <= 1'b0;
                  berr_seen_q <= 1'b0;
                end
              end
              default: st_q <= st_q;
            endcase
          end
        end
      end
      if (!sel_active && sel_q) begin
        local_data_lines_oe <= 1'b0; // [RL18]
        local_bus_error_n <= 1'b1; // [RL19]
        vme_dtack_n <= 1'b1;
        vme_berr_n <= 1'b1;
      end
      // bus grant passes down the chain unless we requested
      vme_bg_out_n <= vme_br_n ? vme_bg_in_n : 1'b1; // [RL11]
      // data path: drain fifo toward the bus once granted
      f_out_rdy <= xfer_active && !vme_bg_in_n && rd_data_ready;
      if (f_out_valid && f_out_rdy) begin
        rd_data <= f_out_data;
        rd_data_valid <= 1'b1;
      end else if (rd_data_ready) begin
        rd_data_valid <= 1'b0;
      end
      if (st_q == ST_XFER && (xfer_done || xfer_berr)) begin
        xfer_active <= 1'b0;
        vme_br_n <= 1'b1;
        berr_seen_q <= xfer_berr;
        if (irq_en_q) begin
          st_q <= ST_IRQ; // [RL11]
          irq_req <= 1'b1;
          irq_status_id <= sid_q;
        end else begin
          st_q <= ST_IDLE;
        end
      end
      if (st_q == ST_IRQ && irq_ack) begin
        irq_req <= 1'b0;
        st_q <= ST_IDLE;
      end
    end
  end
endmodule // vmb_ctrl

// ### testbench/vmb_monitor.sv
`timescale 1ns/1ps
module vmb_monitor (
  // clock and reset
  input logic core_clk,
  input logic rst_b,
  // lock decode inputs
  input logic [3:0] lock_region,
  input logic [4:0] lock_cmd_enable,
  input logic [15:0] region_vec,
  input logic vme_as_n,
  input logic vme_bbsy_n,
  input logic vme_ds_n,
  input logic vme_lock_cycle,
  input logic [2:0] vme_lock_space,
  // local register port
  input logic register_select_n,
  input logic local_write,
  input logic holdoff_active,
  input logic local_data_lines_oe,
  input logic local_bus_error_n,
  input logic local_cycle_inhibit,
  // lock output
  input logic lock_indicator_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_lock_cmd;
    vme_lock_cycle && !vme_as_n && vme_ds_n && region_vec[lock_region] &&
      lock_cmd_enable[vme_lock_space];
  endsequence
  sequence s_read_held;
    !register_select_n[*4] ##0 (holdoff_active && !local_write);
  endsequence
  // reset itself is the antecedent here, so the default disable is lifted
  property p_rst;
    disable iff (1'b0) !rst_b |=> lock_indicator_out &&
      !local_data_lines_oe && local_bus_error_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_lock_on;
    s_lock_cmd |-> ##[1:2] !lock_indicator_out;
  endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock late");
  property p_lock_hold;
    !lock_indicator_out && !vme_bbsy_n |=> !lock_indicator_out;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock lost");
  property p_reg_lock;
    !register_select_n[*4] |-> !lock_indicator_out;
  endproperty
  a_reg_lock: assert property (p_reg_lock) else $error("no lock");
  property p_answer;
    s_read_held |-> local_data_lines_oe || !local_bus_error_n;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no read answer");
  property p_no_early;
    $fell(register_select_n) |-> !local_data_lines_oe [*2];
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("data driven early");
  property p_release;
    register_select_n [*2] |-> !local_data_lines_oe && local_bus_error_n;
  endproperty
  a_release: assert property (p_release)
    else $error("lines not released");
  property p_inhibit;
    !register_select_n [*2] |-> local_cycle_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("no inhibit");
endmodule // vmb_monitor

// ### testbench/vmb_local_host.sv
`timescale 1ns/1ps
module vmb_local_host #(
  parameter SEL_CYC = 13
) (
  // clock
  input logic core_clk,
  // shared lines seen by the host
  input logic [31:0] local_data_lines_in,
  input logic local_bus_error_n,
  // register access controls
  output logic register_select_n,
  output logic [2:0] register_index_lines,
  output logic local_write,
  output logic holdoff_active,
  output logic [31:0] host_ld
);
  initial begin
    register_select_n = 1'b1;
    register_index_lines = 3'h0;
    local_write = 1'b0;
    holdoff_active = 1'b0;
    host_ld = 32'h5a5a_a5a5;
  end
  // no acknowledge comes back, so the select is held a fixed time
  task access(input [2:0] x, input w, input [31:0] d,
    output [7:0] r, output e);
    @(negedge core_clk);
    holdoff_active = 1'b1;
    register_index_lines = x;
    local_write = w;
    // on reads the host value flips so stale data cannot pass
    host_ld = w ? d : ~host_ld;
    @(negedge core_clk);
    register_select_n = 1'b0;
    repeat (SEL_CYC) @(negedge core_clk);
    r = local_data_lines_in[7:0];
    e = local_bus_error_n;
    register_select_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
endmodule // vmb_local_host

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0, rst_b = 1'b0, lock_default_disable = 1'b0;
  logic vme_as_n = 1'b1, vme_bbsy_n = 1'b1, vme_ds_n = 1'b1;
  logic vme_lock_cycle = 1'b0, vme_write = 1'b0, vme_bg_in_n = 1'b1;
  logic xfer_done = 1'b0, irq_ack = 1'b0, xfer_berr = 1'b0;
  logic wr_data_valid = 1'b0, rd_data_ready = 1'b1, er, lk;
  logic [31:0] wd;
  logic [3:0] lock_region = 4'h3;
  logic [4:0] lock_cmd_enable = 5'h14;
  logic [15:0] region_vec = 16'h0000;
  logic [2:0] vme_lock_space = 3'h0;
  logic [7:0] vme_wdata = 8'h00, rd;
  logic [31:0] wr_data = 32'h0;
  integer errors = 0, n_tests = 0, i, k, n_loads = 0;
  wire vme_dtack_n, vme_berr_n, register_select_n, local_write;
  wire holdoff_active, local_data_lines_oe, local_bus_error_n, irq_req;
  wire local_cycle_inhibit, load_local_addr, load_vme_addr, vme_br_n;
  wire vme_bg_out_n, xfer_active, wr_data_ready, rd_data_valid;
  wire lock_indicator_out;
  wire [7:0] vme_rdata, xfer_type, irq_status_id;
  wire [2:0] register_index_lines;
  wire [3:0] chip_sel, byte_en;
  wire [19:0] xfer_len;
  wire [31:0] host_ld, local_data_lines_out, start_addr_out, rd_data;
  // the device wins the shared data lines while it drives them
  wire [31:0] local_data_lines_in =
    local_data_lines_oe ? local_data_lines_out : host_ld;

  always #4 core_clk = ~core_clk;
  vmb_ctrl DUT (.*);
  vmb_local_host u_host (.*);
  // address load strobes, counted so each start write shows its pulse
  always @(posedge core_clk)
    if (rst_b)
      n_loads <= n_loads + load_local_addr + load_vme_addr;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task acc(input [2:0] x, input w, input [31:0] d);
    u_host.access(x, w, d, rd, er);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task t_reset;
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    chk("lock idle", 1, lock_indicator_out);
    chk("data oe", 0, local_data_lines_oe);
    chk("bus error", 1, local_bus_error_n);
    $display("test reset done");
  endtask
  task t_regs;
    acc(3'h3, 1'b0, 32'h0);
    chk("early error", 0, er);
    acc(3'h0, 1'b0, 32'h0);
    chk("sema idle", 1, rd[0]);
    acc(3'h0, 1'b0, 32'h0);
    chk("sema busy", 0, rd[0]);
    for (i = 1; i < 8; i++)
      if (i != 4) begin
        wd = i == 1 ? 32'h1 : i == 3 ? 32'h52 : i == 2 ? 32'h0 : 32'h11 * i;
        acc(i[2:0], 1'b1, wd);
        chk("reg write", 1, er);
        acc(i[2:0], 1'b0, 32'h0);
        chk("reg read", wd[7:0], rd);
      end
    // vme side: region valid and data strobe low at the select
    region_vec = 16'h0001;
    vme_ds_n = 1'b0;
    fork
      acc(3'h3, 1'b0, 32'h0);
      begin
        repeat (6) @(negedge core_clk);
        chk("dtack", 0, vme_dtack_n);
      end
    join
    chk("vme read", 32'h52, vme_rdata);
    fork
      acc(3'h0, 1'b1, 32'h0);
      begin
        repeat (6) @(negedge core_clk);
        chk("berr", 0, vme_berr_n);
      end
    join
    chk("sema write", 0, er);
    region_vec = 16'h0000;
    vme_ds_n = 1'b1;
    $display("test registers done");
  endtask
  task t_xfer(input logic dis);
    lock_default_disable = dis;
    acc(3'h0, 1'b0, 32'h0);
    chk("sema idle", 1, rd[0]);
    // second pass arms the completion interrupt
    if (dis)
      acc(3'h7, 1'b1, 32'h1a5);
    k = n_loads;
    acc(3'h5, 1'b1, 32'h100);
    chk("vme start", 32'h100, start_addr_out);
    acc(3'h4, 1'b1, 32'h200);
    chk("go error", 1, er);
    chk("local start", 32'h200, start_addr_out);
    chk("loads", k + 2, n_loads);
    for (k = 0; k < 99 && vme_br_n !== 1'b0; k++) @(negedge core_clk);
    chk("bus request", 0, vme_br_n);
    // fill while the drain side waits for the grant, then drain in order
    region_vec = 16'h0004;
    for (i = 0; i < 4; i++) begin
      wr_data = 32'h10 + i;
      wr_data_valid = 1'b1;
      @(negedge core_clk);
    end
    wr_data_valid = 1'b0;
    chk("fifo full", 0, wr_data_ready);
    vme_bg_in_n = 1'b0;
    i = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (rd_data_valid === 1'b1 && i < 4) begin
        chk("fifo order", 32'h10 + i, rd_data);
        i = i + 1;
      end
    end
    chk("fifo drained", 4, i);
    chk("active", 1, xfer_active);
    chk("type", 32'h52, xfer_type);
    chk("length", 32'h1, xfer_len);
    chk("default lock", dis, lock_indicator_out);
    chk("grant held", 1, vme_bg_out_n);
    chk("master selects", 32'h4f, {chip_sel, byte_en});
    xfer_done = 1'b1;
    @(negedge core_clk);
    xfer_done = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("finished", 0, xfer_active);
    chk("grant passed", 0, vme_bg_out_n);
    chk("irq", dis, irq_req);
    chk("status id", dis ? 32'ha5 : 32'h0, irq_status_id);
    irq_ack = 1'b1;
    @(negedge core_clk);
    irq_ack = 1'b0;
    chk("irq served", 0, irq_req);
    vme_bg_in_n = 1'b1;
    region_vec = 16'h0000;
    $display("test transfer done");
  endtask
  // the last pass hits a region other than the lock region
  task t_lock;
    for (i = 0; i < 6; i++) begin
      region_vec = i == 5 ? 16'h0010 : 16'h0008;
      vme_lock_space = i == 5 ? 3'h2 : i[2:0];
      lk = i < 5 ? !lock_cmd_enable[i] : 1'b1;
      vme_lock_cycle = 1'b1;
      vme_as_n = 1'b0;
      vme_bbsy_n = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("lock on", lk, lock_indicator_out);
      chk("selects", 0, {chip_sel, byte_en});
      vme_as_n = 1'b1;
      vme_lock_cycle = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("lock held", lk, lock_indicator_out);
      vme_bbsy_n = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("lock free", 1, lock_indicator_out);
    end
    // a plain slave cycle in the lock region still gets its selects
    region_vec = 16'h0008;
    vme_as_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("slave selects", 32'h8f, {chip_sel, byte_en});
    chk("slave no lock", 1, lock_indicator_out);
    vme_as_n = 1'b1;
    region_vec = 16'h0000;
    $display("test lock done");
  endtask
  initial begin
    t_reset;
    t_regs;
    t_xfer(1'b0);
    t_xfer(1'b1);
    t_lock;
    final_report;
  end
  // roughly ten times the expected length of the run
  initial begin
    #40000;
    errors = errors + 1;
    final_report;
  end
endmodule // tb_top
bind vmb_ctrl vmb_monitor u_mon (.*);
